// File: lpaps_defines.svh
// Register indices, field positions, reset values and bus codes of the parameter block
`ifndef LPAPS_DEFINES_SVH
`define LPAPS_DEFINES_SVH

// Register indices; byte address is four times the index
`define LPAPS_IDX_VIS_GAIN   6'h11
`define LPAPS_IDX_VISIBLE_HIGH_RANGE_SELECT  6'h12
`define LPAPS_IDX_AMB_HYST   6'h16
`define LPAPS_IDX_PROX_HYST  6'h17
`define LPAPS_IDX_PROX_PERS  6'h18
`define LPAPS_IDX_AMB_PERS   6'h19
`define LPAPS_IDX_OFFSET     6'h1a
`define LPAPS_IDX_IRQ_STAT   6'h20
`define LPAPS_IDX_IRQ_CLR    6'h21
`define LPAPS_IDX_IRQ_EN     6'h22
`define LPAPS_IDX_STATUS     6'h23

// Reset values
`define LPAPS_RST_VIS_GAIN   8'h00
`define LPAPS_RST_VISIBLE_HIGH_RANGE_SELECT  8'h00
`define LPAPS_RST_HYST       8'h48
`define LPAPS_RST_PERS       8'h03
`define LPAPS_RST_OFFSET     8'h80
`define LPAPS_RST_IRQ        5'h00

// Field positions
`define LPAPS_GAIN_MSB       2
`define LPAPS_RANGE_BIT      5
`define LPAPS_EXP_MSB        7
`define LPAPS_EXP_LSB        4
`define LPAPS_MANT_MSB       3

// Result codes
`define LPAPS_OVERRANGE      16'hffff
`define LPAPS_MAX_RESULT     16'hfffe

// Bus response codes
`define LPAPS_RESP_OKAY      2'h0
`define LPAPS_RESP_SLVERR    2'h2

`endif

// File: lpaps_pkg.sv
// Types shared by the parameter block modules
package lpaps_pkg;
   typedef logic [15:0] lpaps_word_t;
   typedef logic [7:0]  lpaps_code_t;
   typedef logic [4:0]  lpaps_chan_t;
endpackage : lpaps_pkg

// File: lpaps_decode_if.sv
// Carrier between a user of a compressed code and its decoder
`timescale 1ns/1ps
interface lpaps_decode_if;
   import lpaps_pkg::*;
   lpaps_code_t code;
   lpaps_word_t value;
   modport src (output code, input value);
   modport dec (input code, output value);
endinterface : lpaps_decode_if

// File: lpaps_decoder.sv
// Expands an 8-bit compressed code into its 16-bit value
`timescale 1ns/1ps
`include "lpaps_defines.svh"
module lpaps_decoder
   import lpaps_pkg::*;
(
   // Code in, value out
   lpaps_decode_if.dec port
);
   // Upper nibble is a shift, lower nibble a fraction behind a hidden one
   logic [19:0] shifted;
   assign shifted = {15'h0000, 1'b1, port.code[`LPAPS_MANT_MSB:0]}
                    << port.code[`LPAPS_EXP_MSB:`LPAPS_EXP_LSB];       // RULE_13
   assign port.value = shifted[19:4];                                  // RULE_13
endmodule : lpaps_decoder

// File: lpaps_param_set.sv
// Gain, range, hysteresis, persistence and offset settings of the light and proximity readout
`timescale 1ns/1ps
`include "lpaps_defines.svh"

// How it works
// RULE_01: Visible integration time grows by two to the power of the gain field.
// RULE_02: Visible gain codes 0, 4, 6 divide the ADC clock by 1, 16, 64.
// RULE_03: On legacy sequencers visible gain and range also drive infrared measurements.
// RULE_04: Range bit 5 picks high signal range, gain reduced by 14.5.
// RULE_05: Ambient hysteresis widens both ambient thresholds, decoded from compressed code.
// RULE_06: Proximity hysteresis widens all three proximity thresholds; 0x48 means 24.
// RULE_07: Proximity status changes after consecutive exceedances chosen by its persistence mask.
// RULE_08: Ambient status changes after consecutive exceedances chosen by its persistence mask.
// RULE_09: A decoded offset is added to every reported measurement; the code passes raw 0xffff unchanged and caps other sums at 0xfffe.
// RULE_10: Value 0xffff is kept for overrange; offset results never reach it.
// RULE_11: Host should set visible recovery period to one's complement of gain.
// RULE_12: Persistence mask acts on a shift register of recent comparison results.
// RULE_13: Compressed decoder hits 0x48=24, 0x60=64, 0x70=128, 0x80=256 exactly.
module lpaps_param_set
   import lpaps_pkg::*;
(
   // Clock and reset
   input  wire  logic        clk,
   input  wire  logic        rst,
   // AXI4-Lite write address and data
   input  wire  logic        s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire  logic [7:0]  s_axi_awaddr,
   input  wire  logic        s_axi_wvalid,
   output logic              s_axi_wready,
   input  wire  logic [31:0] s_axi_wdata,
   input  wire  logic [3:0]  s_axi_wstrb,
   // AXI4-Lite write response
   output logic              s_axi_bvalid,
   input  wire  logic        s_axi_bready,
   output logic [1:0]        s_axi_bresp,
   // AXI4-Lite read
   input  wire  logic        s_axi_arvalid,
   output logic              s_axi_arready,
   input  wire  logic [7:0]  s_axi_araddr,
   output logic              s_axi_rvalid,
   input  wire  logic        s_axi_rready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   // Raw measurements, one strobe per sample set
   input  wire  logic        sample_valid,
   input  wire  lpaps_word_t raw_ambient,
   input  wire  lpaps_word_t raw_prox1,
   input  wire  lpaps_word_t raw_prox2,
   input  wire  lpaps_word_t raw_prox3,
   // Thresholds held elsewhere
   input  wire  lpaps_word_t ambient_low_threshold,
   input  wire  lpaps_word_t ambient_high_threshold,
   input  wire  lpaps_word_t prox_channel1_threshold,
   input  wire  lpaps_word_t prox_channel2_threshold,
   input  wire  lpaps_word_t prox_channel3_threshold,
   // Infrared settings and sequencer generation
   input  wire  logic        legacy_sequencer,
   input  wire  logic [2:0]  ir_gain_setting,
   input  wire  logic        ir_range_setting,
   // ADC steering
   output logic [7:0]        visible_clock_divide,
   output logic              visible_high_range_select,
   output logic [7:0]        ir_clock_divide,
   output logic              ir_high_range_select,
   // Reported results and status
   output logic              result_valid,
   output lpaps_word_t       result_ambient,
   output lpaps_word_t       result_prox1,
   output lpaps_word_t       result_prox2,
   output lpaps_word_t       result_prox3,
   output lpaps_chan_t       channel_status,
   output logic              irq
);
   // Setting registers
   lpaps_code_t vis_gain_reg, visible_high_range_select_reg, amb_hyst_reg, prox_hyst_reg;
   lpaps_code_t prox_pers_reg, amb_pers_reg, offset_reg;
   lpaps_chan_t irq_stat_reg, irq_en_reg, status_reg;

   // Bus state
   logic        aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
   logic [5:0]  aw_idx_reg;
   logic [7:0]  w_data_reg;
   logic        w_lane_reg;
   logic [1:0]  bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;

   // Decoders for the three compressed codes
   lpaps_decode_if amb_hyst_if ();
   lpaps_decode_if prox_hyst_if ();
   lpaps_decode_if offset_if ();
   assign amb_hyst_if.code  = amb_hyst_reg;
   assign prox_hyst_if.code = prox_hyst_reg;
   assign offset_if.code    = offset_reg;
   lpaps_decoder u_amb_hyst  (.port(amb_hyst_if));
   lpaps_decoder u_prox_hyst (.port(prox_hyst_if));
   lpaps_decoder u_offset    (.port(offset_if));

   // Write channel handshakes
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take  = s_axi_wvalid & s_axi_wready;
   wire wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
   assign s_axi_awready = ~aw_hold_reg;
   assign s_axi_wready  = ~w_hold_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;

   // Write decode; only byte lane 0 carries a register
   wire wr_lane  = wr_fire & w_lane_reg;
   wire wr_gain  = wr_lane & (aw_idx_reg == `LPAPS_IDX_VIS_GAIN);
   wire wr_range = wr_lane & (aw_idx_reg == `LPAPS_IDX_VISIBLE_HIGH_RANGE_SELECT);
   wire wr_ahyst = wr_lane & (aw_idx_reg == `LPAPS_IDX_AMB_HYST);
   wire wr_physt = wr_lane & (aw_idx_reg == `LPAPS_IDX_PROX_HYST);
   wire wr_ppers = wr_lane & (aw_idx_reg == `LPAPS_IDX_PROX_PERS);
   wire wr_apers = wr_lane & (aw_idx_reg == `LPAPS_IDX_AMB_PERS);
   wire wr_ofs   = wr_lane & (aw_idx_reg == `LPAPS_IDX_OFFSET);
   wire wr_clr   = wr_lane & (aw_idx_reg == `LPAPS_IDX_IRQ_CLR);
   wire wr_en    = wr_lane & (aw_idx_reg == `LPAPS_IDX_IRQ_EN);
   wire wr_hit   = (aw_idx_reg == `LPAPS_IDX_VIS_GAIN)  | (aw_idx_reg == `LPAPS_IDX_VISIBLE_HIGH_RANGE_SELECT)
                 | (aw_idx_reg == `LPAPS_IDX_AMB_HYST)  | (aw_idx_reg == `LPAPS_IDX_PROX_HYST)
                 | (aw_idx_reg == `LPAPS_IDX_PROX_PERS) | (aw_idx_reg == `LPAPS_IDX_AMB_PERS)
                 | (aw_idx_reg == `LPAPS_IDX_OFFSET)    | (aw_idx_reg == `LPAPS_IDX_IRQ_CLR)
                 | (aw_idx_reg == `LPAPS_IDX_IRQ_EN);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `LPAPS_RESP_OKAY;
         aw_idx_reg  <= 6'h00;
         w_data_reg  <= 8'h00;
         w_lane_reg  <= 1'b0;
      end else begin
         if (aw_take) begin
            aw_hold_reg <= 1'b1;
            aw_idx_reg  <= s_axi_awaddr[7:2];
         end else if (wr_fire) begin
            aw_hold_reg <= 1'b0;
         end
         if (w_take) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata[7:0];
            w_lane_reg <= s_axi_wstrb[0];
         end else if (wr_fire) begin
            w_hold_reg <= 1'b0;
         end
         if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? `LPAPS_RESP_OKAY : `LPAPS_RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // Setting registers; reserved bits are kept at zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vis_gain_reg  <= `LPAPS_RST_VIS_GAIN;
         visible_high_range_select_reg <= `LPAPS_RST_VISIBLE_HIGH_RANGE_SELECT;
         amb_hyst_reg  <= `LPAPS_RST_HYST;
         prox_hyst_reg <= `LPAPS_RST_HYST;
         prox_pers_reg <= `LPAPS_RST_PERS;
         amb_pers_reg  <= `LPAPS_RST_PERS;
         offset_reg    <= `LPAPS_RST_OFFSET;
         irq_en_reg    <= `LPAPS_RST_IRQ;
      end else begin
         if (wr_gain)  vis_gain_reg  <= {5'h00, w_data_reg[`LPAPS_GAIN_MSB:0]};
         if (wr_range) visible_high_range_select_reg <= {2'h0, w_data_reg[`LPAPS_RANGE_BIT], 5'h00};
         if (wr_ahyst) amb_hyst_reg  <= w_data_reg;
         if (wr_physt) prox_hyst_reg <= w_data_reg;
         if (wr_ppers) prox_pers_reg <= w_data_reg;
         if (wr_apers) amb_pers_reg  <= w_data_reg;
         if (wr_ofs)   offset_reg    <= w_data_reg;
         if (wr_en)    irq_en_reg    <= w_data_reg[4:0];
      end
   end

   // Read channel
   wire [5:0] ar_idx = s_axi_araddr[7:2];
   wire [7:0] rd_byte =
      (ar_idx == `LPAPS_IDX_VIS_GAIN)  ? vis_gain_reg  :
      (ar_idx == `LPAPS_IDX_VISIBLE_HIGH_RANGE_SELECT) ? visible_high_range_select_reg :
      (ar_idx == `LPAPS_IDX_AMB_HYST)  ? amb_hyst_reg  :
      (ar_idx == `LPAPS_IDX_PROX_HYST) ? prox_hyst_reg :
      (ar_idx == `LPAPS_IDX_PROX_PERS) ? prox_pers_reg :
      (ar_idx == `LPAPS_IDX_AMB_PERS)  ? amb_pers_reg  :
      (ar_idx == `LPAPS_IDX_OFFSET)    ? offset_reg    :
      (ar_idx == `LPAPS_IDX_IRQ_STAT)  ? {3'h0, irq_stat_reg} :
      (ar_idx == `LPAPS_IDX_IRQ_EN)    ? {3'h0, irq_en_reg}   :
      (ar_idx == `LPAPS_IDX_STATUS)    ? {3'h0, status_reg}   : 8'h00;
   // Clear register is write-only and so reads as unmapped
   wire rd_hit = (ar_idx == `LPAPS_IDX_VIS_GAIN)  | (ar_idx == `LPAPS_IDX_VISIBLE_HIGH_RANGE_SELECT)
               | (ar_idx == `LPAPS_IDX_AMB_HYST)  | (ar_idx == `LPAPS_IDX_PROX_HYST)
               | (ar_idx == `LPAPS_IDX_PROX_PERS) | (ar_idx == `LPAPS_IDX_AMB_PERS)
               | (ar_idx == `LPAPS_IDX_OFFSET)    | (ar_idx == `LPAPS_IDX_IRQ_STAT)
               | (ar_idx == `LPAPS_IDX_IRQ_EN)    | (ar_idx == `LPAPS_IDX_STATUS);
   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= `LPAPS_RESP_OKAY;
      end else if (s_axi_arvalid & ~rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= {24'h00_0000, rd_byte};
         rresp_reg  <= rd_hit ? `LPAPS_RESP_OKAY : `LPAPS_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // ADC steering; legacy sequencers have no separate infrared settings
   wire [2:0] vis_gain = vis_gain_reg[`LPAPS_GAIN_MSB:0];
   wire       vis_hi   = visible_high_range_select_reg[`LPAPS_RANGE_BIT];
   wire [2:0] ir_gain  = legacy_sequencer ? vis_gain : ir_gain_setting;   // RULE_03
   wire       ir_hi    = legacy_sequencer ? vis_hi : ir_range_setting;    // RULE_03

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         visible_clock_divide      <= 8'h01;
         visible_high_range_select <= 1'b0;
         ir_clock_divide           <= 8'h01;
         ir_high_range_select      <= 1'b0;
      end else begin
         visible_clock_divide      <= 8'h01 << vis_gain;   // RULE_01 RULE_02
         visible_high_range_select <= vis_hi;              // RULE_04
         ir_clock_divide           <= 8'h01 << ir_gain;    // RULE_03
         ir_high_range_select      <= ir_hi;               // RULE_03
      end
   end

   // Offset addition; raw overrange passes unchanged, other sums stop short of it
   lpaps_word_t raw [4];
   lpaps_word_t adj [4];
   assign raw[0] = raw_ambient;
   assign raw[1] = raw_prox1;
   assign raw[2] = raw_prox2;
   assign raw[3] = raw_prox3;
   for (genvar k = 0; k < 4; k++) begin : g_ofs
      wire [16:0] sum = {1'b0, raw[k]} + {1'b0, offset_if.value};         // RULE_09
      assign adj[k] = (raw[k] == `LPAPS_OVERRANGE) ? `LPAPS_OVERRANGE :
                      (sum >= {1'b0, `LPAPS_OVERRANGE}) ? `LPAPS_MAX_RESULT :
                      sum[15:0];                                          // RULE_10
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         result_valid   <= 1'b0;
         result_ambient <= 16'h0000;
         result_prox1   <= 16'h0000;
         result_prox2   <= 16'h0000;
         result_prox3   <= 16'h0000;
      end else begin
         result_valid <= sample_valid;
         if (sample_valid) begin
            result_ambient <= adj[0];
            result_prox1   <= adj[1];
            result_prox2   <= adj[2];
            result_prox3   <= adj[3];
         end
      end
   end

   // Status channels: 0 ambient high, 1 ambient low (falling), 2..4 proximity
   lpaps_word_t ch_val [5];
   lpaps_word_t ch_th  [5];
   lpaps_word_t ch_hys [5];
   lpaps_code_t ch_msk [5];
   lpaps_code_t hist_reg  [5];
   lpaps_code_t hist_next [5];
   lpaps_chan_t flip;
   assign ch_val = '{adj[0], adj[0], adj[1], adj[2], adj[3]};
   assign ch_th  = '{ambient_high_threshold, ambient_low_threshold, prox_channel1_threshold,
                     prox_channel2_threshold, prox_channel3_threshold};
   assign ch_hys = '{amb_hyst_if.value, amb_hyst_if.value, prox_hyst_if.value,
                     prox_hyst_if.value, prox_hyst_if.value};               // RULE_05 RULE_06
   assign ch_msk = '{amb_pers_reg, amb_pers_reg, prox_pers_reg, prox_pers_reg, prox_pers_reg};

   for (genvar c = 0; c < 5; c++) begin : g_chan
      wire [16:0]  up_sum = {1'b0, ch_th[c]} + {1'b0, ch_hys[c]};
      wire [15:0]  up     = up_sum[16] ? `LPAPS_OVERRANGE : up_sum[15:0];
      wire [15:0]  dn     = (ch_th[c] > ch_hys[c]) ? 16'(ch_th[c] - ch_hys[c]) : 16'h0000;
      wire         above  = ch_val[c] > up;
      wire         below  = ch_val[c] < dn;
      // Falling channel enters below the band and leaves above it
      wire         enter  = (c == 1) ? below : above;
      wire         leave  = (c == 1) ? above : below;
      wire         beyond = status_reg[c] ? leave : enter;
      assign hist_next[c] = {hist_reg[c][6:0], beyond};                   // RULE_12
      assign flip[c] = sample_valid & (ch_msk[c] != 8'h00)
                     & ((hist_next[c] & ch_msk[c]) == ch_msk[c]);         // RULE_07 RULE_08
      // History restarts after a change so the next change needs a fresh run
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            hist_reg[c] <= 8'h00;
         end else if (sample_valid) begin
            hist_reg[c] <= flip[c] ? 8'h00 : hist_next[c];                // RULE_12
         end
      end
   end

   // Status and sticky events; a new event beats a simultaneous clear
   wire [4:0] clr_bits = wr_clr ? w_data_reg[4:0] : 5'h00;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_reg   <= 5'h00;
         irq_stat_reg <= `LPAPS_RST_IRQ;
      end else begin
         status_reg   <= status_reg ^ flip;                                // RULE_07 RULE_08
         irq_stat_reg <= (irq_stat_reg & ~clr_bits) | flip;
      end
   end
   assign channel_status = status_reg;
   assign irq = |(irq_stat_reg & irq_en_reg);

   // Checks
   gain_divide_a: assert property (@(posedge clk) disable iff (rst)   // RULE_01
      wr_gain |=> ##1 visible_clock_divide == (8'h01 << $past(w_data_reg[2:0], 2)))
      else $error("visible divide does not follow gain write");
   gain_codes_a: assert property (@(posedge clk) disable iff (rst)   // RULE_02
      $past(vis_gain) == 3'h4 |-> visible_clock_divide == 8'h10)
      else $error("gain code 4 does not divide by 16");
   legacy_ir_a: assert property (@(posedge clk) disable iff (rst)   // RULE_03
      $past(legacy_sequencer) |-> ir_clock_divide == visible_clock_divide
                                  && ir_high_range_select == visible_high_range_select)
      else $error("legacy infrared settings differ from visible");
   range_bit_a: assert property (@(posedge clk) disable iff (rst)   // RULE_04
      wr_range |=> ##1 visible_high_range_select == $past(w_data_reg[5], 2))
      else $error("range select does not follow bit 5");
   amb_hyst_a: assert property (@(posedge clk) disable iff (rst)   // RULE_05
      amb_hyst_reg == 8'h48 |-> amb_hyst_if.value == 16'h0018)
      else $error("ambient hysteresis code 0x48 not 24");
   prox_hyst_a: assert property (@(posedge clk) disable iff (rst)   // RULE_06
      prox_hyst_reg == 8'h48 |-> prox_hyst_if.value == 16'h0018)
      else $error("proximity hysteresis code 0x48 not 24");
   prox_persist_a: assert property (@(posedge clk) disable iff (rst)   // RULE_07
      $changed(status_reg[4:2]) |-> $past(sample_valid)
                                    && $past(prox_pers_reg) != 8'h00)
      else $error("proximity status changed without a persisting sample");
   amb_persist_a: assert property (@(posedge clk) disable iff (rst)   // RULE_08
      $changed(status_reg[0]) |->
         ($past(hist_next[0]) & $past(amb_pers_reg)) == $past(amb_pers_reg))
      else $error("ambient status changed before its run completed");
   offset_add_a: assert property (@(posedge clk) disable iff (rst)   // RULE_09
      sample_valid && raw_ambient < 16'h8000 && offset_reg == 8'h80
      |=> result_ambient == $past(raw_ambient) + 16'h0100)
      else $error("offset 0x80 not added as 256");
   no_marker_a: assert property (@(posedge clk) disable iff (rst)   // RULE_10
      sample_valid && raw_prox1 != 16'hffff |=> result_prox1 != 16'hffff)
      else $error("offset result reported as overrange");
   decode_pts_a: assert property (@(posedge clk) disable iff (rst)   // RULE_13
      offset_reg == 8'h70 |-> offset_if.value == 16'h0080)
      else $error("offset code 0x70 not 128");
   set_wins_a: assert property (@(posedge clk) disable iff (rst)
      flip[0] && clr_bits[0] |=> irq_stat_reg[0])
      else $error("event lost against clear");
endmodule : lpaps_param_set

// File: lpaps_sample_src.sv
// Behavioural source of raw measurement sets for the parameter block
`timescale 1ns/1ps
module lpaps_sample_src
   import lpaps_pkg::*;
(
   // Clock
   input  wire  logic  clk,
   // Raw sample set
   output logic        sample_valid,
   output lpaps_word_t raw_ambient,
   output lpaps_word_t raw_prox1,
   output lpaps_word_t raw_prox2,
   output lpaps_word_t raw_prox3
);
   initial begin
      sample_valid = 1'b0;
      {raw_ambient, raw_prox1, raw_prox2, raw_prox3} = '0;
   end
   // Values are inverted after the strobe so stale data cannot pass for fresh
   task automatic send(input lpaps_word_t v);
      @(posedge clk);
      sample_valid <= 1'b1;
      {raw_ambient, raw_prox1, raw_prox2, raw_prox3} <= {4{v}};
      @(posedge clk);
      sample_valid <= 1'b0;
      {raw_ambient, raw_prox1, raw_prox2, raw_prox3} <= {4{~v}};
   endtask : send
endmodule : lpaps_sample_src

// File: light_prox_adc_param_set_tb.sv
// Self-checking bench of the light and proximity parameter block
`timescale 1ns/1ps
module light_prox_adc_param_set_tb
   import lpaps_pkg::*;
;
   logic clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr, s_axi_araddr, visible_clock_divide, ir_clock_divide, v;
   logic [31:0] s_axi_wdata, s_axi_rdata, r;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic legacy_sequencer, ir_range_setting, visible_high_range_select, ir_high_range_select;
   logic [2:0] ir_gain_setting, eg;
   logic sample_valid, result_valid, irq;
   lpaps_word_t raw_ambient, raw_prox1, raw_prox2, raw_prox3, th, tl, e;
   lpaps_word_t result_ambient, result_prox1, result_prox2, result_prox3;
   lpaps_chan_t channel_status;
   int n_errors, tests_run;
   logic [33:0] rq[$];
   lpaps_word_t sq[$];
   logic [7:0] adr_t[7] = '{8'h44, 8'h48, 8'h58, 8'h5c, 8'h60, 8'h64, 8'h68};
   logic [7:0] rst_t[7] = '{8'h00, 8'h00, 8'h48, 8'h48, 8'h03, 8'h03, 8'h80};
   logic [7:0] msk_t[7] = '{8'h07, 8'h20, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
   logic [7:0] ofc_t[3] = '{8'h60, 8'h70, 8'h80};
   lpaps_word_t ofv_t[3] = '{16'h0040, 16'h0080, 16'h0100};

   lpaps_param_set i_dut (.clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_bvalid,
      .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
      .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .sample_valid, .raw_ambient,
      .raw_prox1, .raw_prox2, .raw_prox3, .ambient_low_threshold(tl),
      .ambient_high_threshold(th), .prox_channel1_threshold(th), .prox_channel2_threshold(th),
      .prox_channel3_threshold(th), .legacy_sequencer, .ir_gain_setting, .ir_range_setting,
      .visible_clock_divide, .visible_high_range_select, .ir_clock_divide,
      .ir_high_range_select, .result_valid, .result_ambient, .result_prox1, .result_prox2,
      .result_prox3, .channel_status, .irq);
   lpaps_sample_src i_src (.clk, .sample_valid, .raw_ambient, .raw_prox1, .raw_prox2,
      .raw_prox3);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task chk(input logic [33:0] got, input logic [33:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task chk_res(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_res

   task report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   task do_reset();
      rst <= 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
   endtask : do_reset

   task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge clk);
         if (!aw && s_axi_awready === 1'b1) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready === 1'b1) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      // Ready stays high so it is never lowered and raised in one step
      do @(posedge clk); while (s_axi_bvalid !== 1'b1);
      chk({32'h0, s_axi_bresp}, {32'h0, er});
   endtask : wr

   task rd(input logic [7:0] a, input logic [33:0] ex);
      rq.push_back(ex);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
   endtask : rd

   // Sample result is checked by the monitor; status settles on the same edge as the result
   task smp(input lpaps_word_t val, input lpaps_word_t ex);
      sq.push_back(ex);
      i_src.send(val);
      @(posedge clk);
   endtask : smp

   always @(posedge clk) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
      if (result_valid === 1'b1) begin
         e = sq.pop_front();
         chk_res({result_ambient, result_prox1, result_prox2, result_prox3}, {4{e}});
      end
   end

   initial begin
      #200us;
      n_errors++;
      report_and_stop();
   end

   initial begin
      n_errors = 0;
      tests_run = 0;
      rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {legacy_sequencer, ir_gain_setting, ir_range_setting} = '0;
      th = 16'hffff;
      tl = 16'h0000;
      void'($urandom(77));
      do_reset();
      foreach (adr_t[i]) rd(adr_t[i], {26'h0, rst_t[i]});
      rd(8'h00, {2'h2, 32'h0});
      wr(8'h04, 8'h55, 2'h2);
      foreach (adr_t[i]) begin
         v = 8'($urandom);
         wr(adr_t[i], v, 2'h0);
         rd(adr_t[i], {26'h0, v & msk_t[i]});
      end
      $display("test registers done");
      for (int g = 0; g < 8; g++) begin
         r = $urandom;
         legacy_sequencer <= r[1];
         ir_gain_setting <= r[4:2];
         ir_range_setting <= r[5];
         wr(8'h44, 8'(g), 2'h0);
         wr(8'h48, {2'b00, r[0], 5'h1f}, 2'h0);
         repeat (2) @(posedge clk);
         eg = r[1] ? 3'(g) : r[4:2];
         chk({26'h0, visible_clock_divide}, {26'h0, 8'(1 << g)});
         chk({33'h0, visible_high_range_select}, {33'h0, r[0]});
         chk({26'h0, ir_clock_divide}, {26'h0, 8'(1 << eg)});
         chk({33'h0, ir_high_range_select}, {33'h0, r[1] ? r[0] : r[5]});
      end
      $display("test gain done");
      do_reset();
      foreach (ofc_t[i]) begin
         wr(8'h68, ofc_t[i], 2'h0);
         smp(16'h0100, 16'h0100 + ofv_t[i]);
      end
      smp(16'hffff, 16'hffff);
      smp(16'hfff0, 16'hfffe);
      $display("test offset done");
      wr(8'h60, 8'h07, 2'h0);
      wr(8'h88, 8'h1f, 2'h0);
      th <= 16'h1000;
      repeat (3) smp(16'h0f18, 16'h1018);
      chk({29'h0, channel_status}, 34'h0);
      smp(16'h0f19, 16'h1019);
      chk({29'h0, channel_status}, 34'h0);
      smp(16'h0f19, 16'h1019);
      chk({28'h0, channel_status, irq}, {28'h0, 5'h01, 1'b1});
      smp(16'h0f19, 16'h1019);
      chk({29'h0, channel_status}, {29'h0, 5'h1d});
      rd(8'h80, {26'h0, 8'h1d});
      rd(8'h8c, {26'h0, 8'h1d});
      wr(8'h84, 8'h1f, 2'h0);
      chk({33'h0, irq}, 34'h0);
      rd(8'h80, 34'h0);
      // Low window: 0x1019 sits inside the hysteresis band, 0x1000 is past it
      tl <= 16'h1030;
      repeat (2) smp(16'h0f19, 16'h1019);
      chk({29'h0, channel_status}, {29'h0, 5'h1d});
      repeat (2) smp(16'h0f00, 16'h1000);
      chk({28'h0, channel_status, irq}, {28'h0, 5'h1f, 1'b1});
      $display("test persistence done");
      repeat (4) @(posedge clk);
      report_and_stop();
   end
endmodule : light_prox_adc_param_set_tb
